// *** rtl/bridge_cfg_map.svh ***
// register offsets, field positions and reset values of the bridge configuration block
// assumes inclusion by bare name from design files
`ifndef BRIDGE_CONFIG_MAP_SVH
`define BRIDGE_CONFIG_MAP_SVH

`define BRIDGE_STATUS_OFFSET 8'h50
`define BRIDGE_CONFIG_OFFSET 8'h54

`define CFG_EXTERNAL_CONTROL_BIT 7
`define CFG_IRQ_EN_BIT 6
`define CFG_REM_EDID_DIS_BIT 5
`define CFG_AUTO_INIT_DISABLE_BIT 4
`define CFG_RESERVED_BIT 3
`define CFG_TDM_BIT 2
`define CFG_AUDIO_SRC_BIT 1
`define CFG_AUX_AUDIO_BIT 0

`define CFG_RESET_VALUE 8'h00
`define CFG_WRITE_MASK 8'hf7

`define STS_IRQ_PENDING_BIT 6
`define STS_INIT_DONE_BIT 4
`define STS_REM_EDID_LOADED_BIT 3

// i2c device address, value arbitrary
`define I2C_DEVICE_ADDR 7'h0c

`endif

// *** rtl/bridge_cfg_pkg.sv ***
// types shared by the bridge configuration block and its i2c register port
// assumes nothing of its surroundings
package bridge_cfg_pkg;

  typedef enum logic [2:0] {
    SEQ_STRAP,
    SEQ_DECIDE,
    SEQ_EDID,
    SEQ_INIT_CHECK,
    SEQ_INIT,
    SEQ_DONE
  } seq_state_t;

  typedef enum logic [3:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ADDR_ACK,
    I2C_PTR,
    I2C_PTR_ACK,
    I2C_WR,
    I2C_WR_ACK,
    I2C_RD,
    I2C_RD_ACK
  } i2c_state_t;

endpackage

// *** rtl/i2c_reg_port.sv ***
// i2c slave giving byte access to an 8-bit register space with auto-increment
// assumes scl and sda arrive synchronous to clk and slow against it
`timescale 1ns/10ps
`include "bridge_cfg_map.svh"

module i2c_reg_port #(
  parameter logic [6:0] DEV_ADDR = `I2C_DEVICE_ADDR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  output logic wr_stb,
  output logic [7:0] wr_data
);

  bridge_cfg_pkg::i2c_state_t state_q;
  logic scl_q, sda_q, rw_q, oe_q, wr_q;
  logic [7:0] shift_q, rd_q, ptr_q, wdat_q;
  logic [3:0] cnt_q;
  logic scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_c = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c = scl_in & scl_q & ~sda_q & sda_in;

  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign reg_addr = ptr_q;
  assign wr_stb = wr_q;
  assign wr_data = wdat_q;

  // line history for edge and condition detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // bit receive shift and count; a byte and its ack bit take nine scl rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
    end else if (start_c || (scl_fall && cnt_q == 4'h9)) begin
      cnt_q <= 4'h0;
    end else if (scl_rise) begin
      shift_q <= {shift_q[6:0], sda_in};
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // transaction sequencing and sda drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= bridge_cfg_pkg::I2C_IDLE;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
      ptr_q <= 8'h00;
      wdat_q <= 8'h00;
      rd_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (start_c) begin
        state_q <= bridge_cfg_pkg::I2C_ADDR;
        oe_q <= 1'b0;
      end else if (stop_c) begin
        state_q <= bridge_cfg_pkg::I2C_IDLE;
        oe_q <= 1'b0;
      end else if (scl_fall) begin
        unique case (state_q)
          bridge_cfg_pkg::I2C_IDLE: begin
            oe_q <= 1'b0;
          end
          bridge_cfg_pkg::I2C_ADDR: begin
            if (cnt_q == 4'h8) begin
              if (shift_q[7:1] == DEV_ADDR) begin
                oe_q <= 1'b1;
                rw_q <= shift_q[0];
                state_q <= bridge_cfg_pkg::I2C_ADDR_ACK;
              end else begin
                state_q <= bridge_cfg_pkg::I2C_IDLE;
              end
            end
          end
          bridge_cfg_pkg::I2C_ADDR_ACK: begin
            if (rw_q) begin
              rd_q <= reg_rdata;
              oe_q <= ~reg_rdata[7];
              state_q <= bridge_cfg_pkg::I2C_RD;
            end else begin
              oe_q <= 1'b0;
              state_q <= bridge_cfg_pkg::I2C_PTR;
            end
          end
          bridge_cfg_pkg::I2C_PTR: begin
            if (cnt_q == 4'h8) begin
              ptr_q <= shift_q;
              oe_q <= 1'b1;
              state_q <= bridge_cfg_pkg::I2C_PTR_ACK;
            end
          end
          bridge_cfg_pkg::I2C_WR: begin
            if (cnt_q == 4'h8) begin
              wdat_q <= shift_q;
              wr_q <= 1'b1;
              oe_q <= 1'b1;
              state_q <= bridge_cfg_pkg::I2C_WR_ACK;
            end
          end
          bridge_cfg_pkg::I2C_PTR_ACK, bridge_cfg_pkg::I2C_WR_ACK: begin
            if (state_q == bridge_cfg_pkg::I2C_WR_ACK) begin
              ptr_q <= ptr_q + 8'h01;
            end
            oe_q <= 1'b0;
            state_q <= bridge_cfg_pkg::I2C_WR;
          end
          bridge_cfg_pkg::I2C_RD: begin
            if (cnt_q == 4'h8) begin
              oe_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              state_q <= bridge_cfg_pkg::I2C_RD_ACK;
            end else begin
              oe_q <= ~rd_q[3'(4'h7 - cnt_q)];
            end
          end
          bridge_cfg_pkg::I2C_RD_ACK: begin
            if (!shift_q[0]) begin
              rd_q <= reg_rdata;
              oe_q <= ~reg_rdata[7];
              state_q <= bridge_cfg_pkg::I2C_RD;
            end else begin
              state_q <= bridge_cfg_pkg::I2C_IDLE;
            end
          end
          default: begin
            state_q <= bridge_cfg_pkg::I2C_IDLE;
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// *** rtl/bridge_config_register.sv ***
// bridge configuration register, status register and the logic they steer
// assumes i2c host access, strap pins stable at reset release, inputs synchronous to CLK
//
// Overview of operation
// [R1] bit 7 set disables internal control and receiver init; loaded from strap one
// [R2] with external control the i2c controller must initialise the receiver itself
// [R3] bit 6 gates receiver interrupts onto active-low interrupt output; resets to zero
// [R4] software may read status register to find whether interrupt came from receiver
// [R5] status bit 6 shows a pending receiver interrupt, read only
// [R6] by default probe remote bus for edid eeprom and copy it locally
// [R7] bit 5 set skips automatic remote edid load; loaded from strap one
// [R8] receiver auto-init runs unless bit 4 or bit 7 set; bit 4 resets to zero
// [R9] bit 2 enables tdm handling of hdmi audio; resets to zero
// [R10] bit 1 picks link audio: zero hdmi, one local i2s
// [R11] bit 0 adds aux two-channel audio stream; loaded from strap zero
// [R12] bit 3 reserved: reads zero, writes ignored
`timescale 1ns/10ps
`include "bridge_cfg_map.svh"

module bridge_config_register #(
  parameter int AUDIO_W = 32,
  parameter logic [6:0] DEV_ADDR = `I2C_DEVICE_ADDR
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic STRAP_PIN_ZERO,
  input wire logic STRAP_PIN_ONE,
  input wire logic HDMI_RX_IRQ,
  output logic INTERRUPT_OUT_N,
  output logic EDID_LOAD_START,
  input wire logic EDID_LOAD_DONE,
  output logic RX_INIT_START,
  input wire logic RX_INIT_DONE,
  output logic EXTERNAL_CONTROL,
  output logic TDM_AUDIO_ENABLE,
  input wire logic [AUDIO_W-1:0] HDMI_AUDIO_WORD,
  input wire logic HDMI_AUDIO_VALID,
  input wire logic [AUDIO_W-1:0] LOCAL_AUDIO_WORD,
  input wire logic LOCAL_AUDIO_VALID,
  output logic [AUDIO_W-1:0] LINK_AUDIO_WORD,
  output logic LINK_AUDIO_VALID,
  input wire logic [AUDIO_W-1:0] AUX_AUDIO_WORD,
  input wire logic AUX_AUDIO_VALID,
  output logic [AUDIO_W-1:0] LINK_AUX_WORD,
  output logic LINK_AUX_VALID
);

  bridge_cfg_pkg::seq_state_t seq_q;
  logic [7:0] cfg_q, reg_addr, reg_rdata, wr_data;
  logic wr_stb, strap_pend_q, irq_pend_q, irq_n_q;
  logic init_done_q, edid_loaded_q, edid_start_q, init_start_q;
  logic [7:0] status_c;

  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  i2c_reg_port #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .clk(CLK),
    .rst(RST),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .sda_out(SDA_OUT),
    .sda_oe(SDA_OE),
    .reg_addr(reg_addr),
    .reg_rdata(reg_rdata),
    .wr_stb(wr_stb),
    .wr_data(wr_data)
  );

  // configuration register, straps caught on the first edge after reset release
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_q <= `CFG_RESET_VALUE; // R3 R8 R9
      strap_pend_q <= 1'b1;
    end else if (strap_pend_q) begin
      strap_pend_q <= 1'b0;
      cfg_q[`CFG_EXTERNAL_CONTROL_BIT] <= STRAP_PIN_ONE; // R1
      cfg_q[`CFG_REM_EDID_DIS_BIT] <= STRAP_PIN_ONE; // R7
      cfg_q[`CFG_AUX_AUDIO_BIT] <= STRAP_PIN_ZERO; // R11
    end else if (wr_stb && hits(reg_addr, `BRIDGE_CONFIG_OFFSET)) begin
      cfg_q <= wr_data & `CFG_WRITE_MASK; // R12
    end
  end

  // status register contents
  always_comb begin
    status_c = 8'h00;
    status_c[`STS_IRQ_PENDING_BIT] = irq_pend_q; // R5 R4
    status_c[`STS_INIT_DONE_BIT] = init_done_q;
    status_c[`STS_REM_EDID_LOADED_BIT] = edid_loaded_q;
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    if (hits(reg_addr, `BRIDGE_CONFIG_OFFSET)) begin
      reg_rdata = cfg_q;
    end else if (hits(reg_addr, `BRIDGE_STATUS_OFFSET)) begin
      reg_rdata = status_c;
    end else begin
      reg_rdata = 8'h00;
    end
  end

  // interrupt pending and reporting
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_pend_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      irq_pend_q <= HDMI_RX_IRQ; // R5
      irq_n_q <= ~(HDMI_RX_IRQ & cfg_q[`CFG_IRQ_EN_BIT]); // R3
    end
  end
  assign INTERRUPT_OUT_N = irq_n_q;

  // start-up sequence: remote edid load, then receiver init
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      seq_q <= bridge_cfg_pkg::SEQ_STRAP;
      edid_start_q <= 1'b0;
      init_start_q <= 1'b0;
      init_done_q <= 1'b0;
      edid_loaded_q <= 1'b0;
    end else begin
      edid_start_q <= 1'b0;
      init_start_q <= 1'b0;
      unique case (seq_q)
        bridge_cfg_pkg::SEQ_STRAP: begin
          seq_q <= bridge_cfg_pkg::SEQ_DECIDE;
        end
        bridge_cfg_pkg::SEQ_DECIDE: begin
          if (!cfg_q[`CFG_REM_EDID_DIS_BIT]) begin
            edid_start_q <= 1'b1; // R6
            seq_q <= bridge_cfg_pkg::SEQ_EDID;
          end else begin
            seq_q <= bridge_cfg_pkg::SEQ_INIT_CHECK; // R7
          end
        end
        bridge_cfg_pkg::SEQ_EDID: begin
          if (EDID_LOAD_DONE) begin
            edid_loaded_q <= 1'b1;
            seq_q <= bridge_cfg_pkg::SEQ_INIT_CHECK;
          end
        end
        bridge_cfg_pkg::SEQ_INIT_CHECK: begin
          if (!cfg_q[`CFG_EXTERNAL_CONTROL_BIT] && !cfg_q[`CFG_AUTO_INIT_DISABLE_BIT]) begin
            init_start_q <= 1'b1; // R8
            seq_q <= bridge_cfg_pkg::SEQ_INIT;
          end else begin
            seq_q <= bridge_cfg_pkg::SEQ_DONE; // R1 R2
          end
        end
        bridge_cfg_pkg::SEQ_INIT: begin
          if (RX_INIT_DONE) begin
            init_done_q <= 1'b1;
            seq_q <= bridge_cfg_pkg::SEQ_DONE;
          end
        end
        bridge_cfg_pkg::SEQ_DONE: begin
          seq_q <= bridge_cfg_pkg::SEQ_DONE;
        end
      endcase
    end
  end
  assign EDID_LOAD_START = edid_start_q;
  assign RX_INIT_START = init_start_q;
  assign EXTERNAL_CONTROL = cfg_q[`CFG_EXTERNAL_CONTROL_BIT];
  assign TDM_AUDIO_ENABLE = cfg_q[`CFG_TDM_BIT]; // R9

  // audio source select onto the link
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LINK_AUDIO_WORD <= '0;
      LINK_AUDIO_VALID <= 1'b0;
    end else if (cfg_q[`CFG_AUDIO_SRC_BIT]) begin
      LINK_AUDIO_WORD <= LOCAL_AUDIO_WORD; // R10
      LINK_AUDIO_VALID <= LOCAL_AUDIO_VALID;
    end else begin
      LINK_AUDIO_WORD <= HDMI_AUDIO_WORD; // R10
      LINK_AUDIO_VALID <= HDMI_AUDIO_VALID;
    end
  end

  // auxiliary two-channel stream
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LINK_AUX_WORD <= '0;
      LINK_AUX_VALID <= 1'b0;
    end else begin
      LINK_AUX_WORD <= AUX_AUDIO_WORD;
      LINK_AUX_VALID <= AUX_AUDIO_VALID & cfg_q[`CFG_AUX_AUDIO_BIT]; // R11
    end
  end

  a_ext_no_init: assert property (@(posedge CLK) disable iff (RST) // R1
    (seq_q == bridge_cfg_pkg::SEQ_INIT_CHECK && cfg_q[`CFG_EXTERNAL_CONTROL_BIT])
    |=> !RX_INIT_START && seq_q == bridge_cfg_pkg::SEQ_DONE)
    else $error("receiver init started under external control");

  a_strap_capture: assert property (@(posedge CLK) disable iff (RST) // R11
    strap_pend_q |=> cfg_q[0] == $past(STRAP_PIN_ZERO) && cfg_q[7] == $past(STRAP_PIN_ONE)
    && cfg_q[5] == $past(STRAP_PIN_ONE))
    else $error("strap values not loaded");

  a_irq_reported: assert property (@(posedge CLK) disable iff (RST) // R3
    (HDMI_RX_IRQ && cfg_q[`CFG_IRQ_EN_BIT]) |=> !INTERRUPT_OUT_N)
    else $error("enabled receiver interrupt not reported");

  a_irq_masked: assert property (@(posedge CLK) disable iff (RST) // R3
    !cfg_q[`CFG_IRQ_EN_BIT] ##1 !cfg_q[`CFG_IRQ_EN_BIT] |-> INTERRUPT_OUT_N)
    else $error("masked interrupt reported");

  a_pending_flag: assert property (@(posedge CLK) disable iff (RST) // R5
    HDMI_RX_IRQ |=> status_c[`STS_IRQ_PENDING_BIT])
    else $error("pending flag missing");

  a_edid_default: assert property (@(posedge CLK) disable iff (RST) // R6
    (seq_q == bridge_cfg_pkg::SEQ_DECIDE && !cfg_q[5]) |=> EDID_LOAD_START)
    else $error("remote edid load not started");

  a_edid_skip: assert property (@(posedge CLK) disable iff (RST) // R7
    (seq_q == bridge_cfg_pkg::SEQ_DECIDE && cfg_q[5]) |=> !EDID_LOAD_START ##1 !EDID_LOAD_START)
    else $error("remote edid load not skipped");

  a_auto_init: assert property (@(posedge CLK) disable iff (RST) // R8
    (seq_q == bridge_cfg_pkg::SEQ_INIT_CHECK) |=> RX_INIT_START == !($past(cfg_q[4]) || $past(cfg_q[7])))
    else $error("auto init decision wrong");

  a_tdm_follow: assert property (@(posedge CLK) disable iff (RST) // R9
    (wr_stb && hits(reg_addr, `BRIDGE_CONFIG_OFFSET) && !strap_pend_q) |=> TDM_AUDIO_ENABLE == $past(wr_data[2]))
    else $error("tdm enable not written");

  a_audio_select: assert property (@(posedge CLK) disable iff (RST) // R10
    cfg_q[1] |=> LINK_AUDIO_WORD == $past(LOCAL_AUDIO_WORD) && LINK_AUDIO_VALID == $past(LOCAL_AUDIO_VALID))
    else $error("local audio not selected");

  a_reserved_zero: assert property (@(posedge CLK) disable iff (RST) // R12
    !cfg_q[`CFG_RESERVED_BIT])
    else $error("reserved bit set");

endmodule

// *** bench/i2c_host_model.sv ***
// i2c host model that reaches the bridge configuration registers
// assumes a pull-up on sda and that the device pulls it low while sda_oe is high
`timescale 1ns/10ps

module i2c_host_model #(
  parameter logic [6:0] DEV = 7'h0c
) (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic pull_low;
  assign sda = ~(pull_low | sda_oe);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  // data changes only while scl is low
  task automatic bit_io(input logic b, output logic r);
    pull_low = ~b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
    half();
  endtask
  task automatic start();
    pull_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    pull_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    pull_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    pull_low = 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic hack, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(~hack, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data,
                    output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer({dev, 1'b0}, 1'b0, rx, a0);
    xfer(ptr, 1'b0, rx, a1);
    xfer(data, 1'b0, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // last byte is not acknowledged by the host
  task automatic rd(input logic [7:0] ptr, output logic [7:0] data);
    logic [7:0] rx;
    logic a;
    start();
    xfer({DEV, 1'b0}, 1'b0, rx, a);
    xfer(ptr, 1'b0, rx, a);
    start();
    xfer({DEV, 1'b1}, 1'b0, rx, a);
    xfer(8'hff, 1'b0, data, a);
    stop();
  endtask
endmodule

// *** bench/bridge_config_register_tb.sv ***
// self-checking bench of the bridge configuration block through its i2c port
// assumes the host model i2c_host_model and a bench-driven edid loader and receiver
`timescale 1ns/10ps

module bridge_config_register_tb;
  localparam logic [15:0] ROWS [9] = '{16'hfff7, 16'h0800, 16'h8080, 16'h2020, 16'h1010,
                                       16'h0404, 16'h0202, 16'h0101, 16'h4040};
  logic clk, rst, scl, sda, sda_out, sda_oe, s0, s1, rx_irq, irq_n;
  logic e_start, e_done, i_start, i_done, external_control_select, tdm_en;
  logic [31:0] h_word, l_word, a_word, link_word, aux_word;
  logic h_valid, l_valid, a_valid, link_valid, aux_valid, ok;
  logic [7:0] rdata, rw;
  int n_mismatch, num_checks, cycles, edid_n, init_n;

  bridge_config_register i_bridge_config_register (.CLK(clk), .RST(rst), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .STRAP_PIN_ZERO(s0),
    .STRAP_PIN_ONE(s1), .HDMI_RX_IRQ(rx_irq), .INTERRUPT_OUT_N(irq_n),
    .EDID_LOAD_START(e_start), .EDID_LOAD_DONE(e_done), .RX_INIT_START(i_start),
    .RX_INIT_DONE(i_done), .EXTERNAL_CONTROL(external_control_select), .TDM_AUDIO_ENABLE(tdm_en),
    .HDMI_AUDIO_WORD(h_word), .HDMI_AUDIO_VALID(h_valid), .LOCAL_AUDIO_WORD(l_word),
    .LOCAL_AUDIO_VALID(l_valid), .LINK_AUDIO_WORD(link_word), .LINK_AUDIO_VALID(link_valid),
    .AUX_AUDIO_WORD(a_word), .AUX_AUDIO_VALID(a_valid), .LINK_AUX_WORD(aux_word),
    .LINK_AUX_VALID(aux_valid));
  i2c_host_model i_i2c_host_model (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      edid_n <= 0;
      init_n <= 0;
    end else begin
      edid_n <= edid_n + int'(e_start);
      init_n <= init_n + int'(i_start);
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic do_reset(input logic z, input logic o);
    s0 = z;
    s1 = o;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
  endtask
  task automatic pulse_edid();
    e_done = 1'b1;
    @(negedge clk);
    e_done = 1'b0;
    repeat (10) @(negedge clk);
  endtask

  initial begin
    cycles = 0;
    n_mismatch = 0;
    num_checks = 0;
    {e_done, i_done, rx_irq, h_valid, l_valid, a_valid} = 6'h00;
    {h_word, l_word, a_word} = {3{32'h0}};
    do_reset(1'b0, 1'b0);
    check("edid start", edid_n[7:0], 8'h01);
    check("early init", init_n[7:0], 8'h00);
    pulse_edid();
    check("init start", init_n[7:0], 8'h01);
    i_done = 1'b1;
    rx_irq = 1'b1;
    for (int k = 0; k < 9; k++) begin
      h_word = 32'h5a5a5a00 + k;
      l_word = 32'ha5a5a500 + k;
      a_word = 32'h3c3c3c00 + k;
      {l_valid, h_valid, a_valid} = {k[1], ~k[0], k[0]};
      rw = ROWS[k][7:0];
      i_i2c_host_model.wr(7'h0c, 8'h54, ROWS[k][15:8], ok);
      check("ack", {7'h00, ok}, 8'h01);
      i_i2c_host_model.rd(8'h54, rdata);
      check("config", rdata, rw);
      check("external_control_select", {7'h00, external_control_select}, {7'h00, rw[7]});
      check("tdm", {7'h00, tdm_en}, {7'h00, rw[2]});
      check("irq out", {7'h00, irq_n}, {7'h00, ~rw[6]});
      check("link word", link_word[7:0], rw[1] ? l_word[7:0] : h_word[7:0]);
      check("link valid", {7'h00, link_valid}, {7'h00, rw[1] ? l_valid : h_valid});
      check("aux valid", {7'h00, aux_valid}, {7'h00, rw[0] & a_valid});
      check("aux word", aux_word[7:0], a_word[7:0]);
    end
    check("sda out", {7'h00, sda_out}, 8'h00);
    rx_irq = 1'b0;
    repeat (3) @(negedge clk);
    check("irq idle", {7'h00, irq_n}, 8'h01);
    i_i2c_host_model.rd(8'h50, rdata);
    check("pending low", {7'h00, rdata[6]}, 8'h00);
    rx_irq = 1'b1;
    i_i2c_host_model.wr(7'h0c, 8'h50, 8'h00, ok);
    i_i2c_host_model.rd(8'h50, rdata);
    check("pending high", {7'h00, rdata[6]}, 8'h01);
    i_i2c_host_model.rd(8'h99, rdata);
    check("unmapped", rdata, 8'h00);
    i_i2c_host_model.wr(7'h0d, 8'h54, 8'h00, ok);
    check("foreign ack", {7'h00, ok}, 8'h00);
    i_i2c_host_model.rd(8'h54, rdata);
    check("kept", rdata, 8'h40);
    do_reset(1'b1, 1'b0);
    i_i2c_host_model.rd(8'h54, rdata);
    check("reset cfg", rdata, 8'h01);
    i_i2c_host_model.wr(7'h0c, 8'h54, 8'h11, ok);
    pulse_edid();
    check("edid once", edid_n[7:0], 8'h01);
    check("no auto init", init_n[7:0], 8'h00);
    do_reset(1'b0, 1'b1);
    i_i2c_host_model.rd(8'h54, rdata);
    check("strap cfg", rdata, 8'ha0);
    check("ext level", {7'h00, external_control_select}, 8'h01);
    check("edid skip", edid_n[7:0], 8'h00);
    check("init skip", init_n[7:0], 8'h00);
    i_i2c_host_model.wr(7'h0c, 8'h54, 8'ha4, ok);
    check("host tdm", {7'h00, tdm_en}, 8'h01);
    results();
  end
endmodule
